// >>> hw/prom_params.svh
// Constants of the serial configuration memory readout block
`ifndef PROM_PARAMS_SVH
`define PROM_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register map (APB byte addresses)
// ----------------------------------------------------------------------------
`define PROM_OFF_STATUS   12'h000
`define PROM_OFF_MEM_ADDR 12'h004
`define PROM_OFF_MEM_DATA 12'h008

// ----------------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------------
`define PROM_MEM_ADDR_RST 32'h0000_0000
`define PROM_PIN_RST      8'he3
`define PROM_ST_STATE_LSB 0
`define PROM_ST_CASC_BIT  4
`define PROM_ST_READY_BIT 5
`define PROM_ST_PSEL_BIT  6
`define PROM_ST_CLKIN_BIT 7
`define PROM_ST_ADDR_LSB  8
`define PROM_ST_BIT_LSB   28

// ----------------------------------------------------------------------------
// Timing and page count
// ----------------------------------------------------------------------------
`define PROM_CLK_SYS_HZ    50000000
`define PROM_POR_TIME_NS   1000
`define PROM_CFG_PERIOD_NS 160
`define PROM_MAX_RATE_HZ   33000000
`define PROM_PAGES         4

`endif

// >>> hw/prom_pkg.sv
// Types shared by the serial configuration memory readout block
package prom_pkg;

    // Readout sequencer states, one-hot
    typedef enum logic [3:0] {
        st_idle = 4'b0001,  // Counters held at start address
        st_read = 4'b0010,  // Streaming stored bits
        st_done = 4'b0100,  // All data out, cascade asserted
        st_prog = 4'b1000   // In-system programming mode
    } read_state_e;

endpackage

// >>> hw/serial_config_prom_readout.sv
// Readout, paging, cascade and standby logic of a serial configuration memory
//
// Contract
// - Reset/OE low clears counters, floats data
// - Chip select high keeps counter off, data floating
// - Reset/OE high with select low enables output
// - Reset/OE low always resets, regardless of select
// - After last bit, release data line
// - Power-up clears the address counter
// - Config clock: input programming, output configuring
// - Paging splits space into four pages
// - Programming mode ignores paging inputs
// - Page codes map to consecutive quarters
// - No paging: terminal is top address
// - Selected and enabled: clock advances, drives data
// - Select high freezes counters, enters standby
// - Programming mode ignores chip select
// - Cascade low at terminal address
// - Cascade stays low, follows select, clears
// - Programming responds only when device selected
// - Ready held low during power-up reset
// - Data pin: three-state read, open-drain program; data_oe stays low in programming mode, so the pin is never driven then
// - Configuration clock rate up to 33 MHz
// - Standby keeps data floating regardless of OE
// - Downstream memory drives on low select
`timescale 1ns/1ns
`include "prom_params.svh"

module serial_config_prom_readout
    import prom_pkg::*;
#(
    parameter int ADDR_W = 20,  // Word address width
    parameter int WORD_W = 16   // Bits per stored word
) (
    input  wire logic        clk_sys,            // System clock, 50 MHz
    input  wire logic        reset_n,            // Async reset, active low
    input  wire logic        reset_or_oe,        // Pin: reset low, enable high
    input  wire logic        chip_select_n,      // Pin: select, active low
    input  wire logic        isp_mode_select_n,  // Pin: low enters programming
    input  wire logic        paging_enable,      // Pin: page mode
    input  wire logic [1:0]  page_select,        // Pin: page number
    input  wire logic        program_device_select, // Pin: programming select
    input  wire logic        config_clock_in,    // Clock pin, input side
    output logic             config_clock_out,   // Clock pin, output side
    output logic             config_clock_oe,    // Clock pin, drive enable
    input  wire logic        data_in,            // Data pin, input side
    output logic             data_out,           // Data pin, output side
    output logic             data_oe,            // Data pin, drive enable
    output logic             cascade_out_n,      // Cascade select output
    output logic             ready_out,          // Ready pin level, always low
    output logic             ready_oe,           // Ready pin pull-down enable
    input  wire logic        psel,               // APB select
    input  wire logic        penable,            // APB access phase
    input  wire logic        pwrite,             // APB direction
    input  wire logic [11:0] paddr,              // APB byte address
    input  wire logic [31:0] pwdata,             // APB write data
    output logic [31:0]      prdata,             // APB read data
    output logic             pready,             // APB ready
    output logic             pslverr             // APB error
);

    // ------------------------------------------------------------------------
    // Derived constants
    // ------------------------------------------------------------------------
    localparam int BIT_W      = $clog2(WORD_W);
    localparam int PAGE_W     = ADDR_W - 2;
    localparam int POR_CYCLES =
        (`PROM_POR_TIME_NS * (`PROM_CLK_SYS_HZ / 1000000) + 999) / 1000;
    localparam int HALF_CYC   =
        (`PROM_CFG_PERIOD_NS * (`PROM_CLK_SYS_HZ / 1000000)) / 2000;
    localparam int MIN_HALF   =
        (`PROM_CLK_SYS_HZ + 2 * `PROM_MAX_RATE_HZ - 1) / (2 * `PROM_MAX_RATE_HZ);
    localparam int NSYNC      = 8;
    // Pull level of each pin in pin_raw order; paging pins pull low
    localparam logic [NSYNC-1:0] SYNC_RST = `PROM_PIN_RST;

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic [NSYNC-1:0] pin_raw;    // Pins from outside the clock domain
    logic [NSYNC-1:0] pin_meta;   // First stage, read by second only
    logic [NSYNC-1:0] pin_sync;   // Second stage, safe to use

    assign pin_raw = {data_in, config_clock_in, program_device_select,
                      page_select, paging_enable, isp_mode_select_n,
                      chip_select_n ^ 1'b0};

    // Pin order in pin_raw is fixed; reset_or_oe handled separately below
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            // Two flops per pin; reset to the pin's pull level so no false page
            always_ff @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    pin_meta[gi] <= SYNC_RST[gi];
                    pin_sync[gi] <= SYNC_RST[gi];
                end else begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    logic roe_meta;   // Reset/OE first stage
    logic roe_s;      // Reset/OE synchronised

    // Reset/OE resets low so nothing drives before it is seen high
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            roe_meta <= 1'b0;
            roe_s    <= 1'b0;
        end else begin
            roe_meta <= reset_or_oe;
            roe_s    <= roe_meta;
        end
    end

    logic       cs_n_s;     // Chip select, synchronised
    logic       cfg_mode;   // Mode select high: configuration readout
    logic       page_en_s;  // Paging enable, synchronised
    logic [1:0] page_s;     // Page number, synchronised
    logic       psel_s;     // Programming select, synchronised
    logic       clk_in_s;   // Clock pin level, synchronised

    assign cs_n_s    = pin_sync[0];
    assign cfg_mode  = pin_sync[1];
    assign page_en_s = pin_sync[2];
    assign page_s    = pin_sync[4:3];
    assign psel_s    = pin_sync[5];
    assign clk_in_s  = pin_sync[6];

    // ------------------------------------------------------------------------
    // Page decode
    // ------------------------------------------------------------------------
    // First word of a page; quarters follow one another
    function automatic logic [ADDR_W-1:0] page_base(input logic en,
                                                    input logic [1:0] pg);
        page_base = en ? {pg, {PAGE_W{1'b0}}} : '0;
    endfunction

    // Last word of a page, or of the whole device when paging is off
    function automatic logic [ADDR_W-1:0] page_top(input logic en,
                                                   input logic [1:0] pg);
        page_top = en ? {pg, {PAGE_W{1'b1}}} : '1;
    endfunction

    logic [ADDR_W-1:0] base_addr;  // Start of the selected range
    logic [ADDR_W-1:0] top_addr;   // Terminal count of the range

    assign base_addr = page_base(page_en_s, page_s);
    assign top_addr  = page_top(page_en_s, page_s);

    // ------------------------------------------------------------------------
    // Power-up reset cycle and ready indicator
    // ------------------------------------------------------------------------
    logic [7:0] por_cnt;   // Cycles left of power-up reset
    logic       por_busy;  // Still in power-up reset

    assign por_busy = (por_cnt != 8'h00);

    // Counts down once after reset release
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            por_cnt <= 8'(POR_CYCLES);
        end else if (por_busy) begin
            por_cnt <= por_cnt - 8'h01;
        end
    end

    // Open drain: pull low only while busy
    assign ready_out = 1'b0;
    assign ready_oe  = por_busy;

    // ------------------------------------------------------------------------
    // Readout sequencer
    // ------------------------------------------------------------------------
    read_state_e state;       // Current state
    read_state_e next_state;  // Next state
    logic        enabled;     // Selected and output enabled
    logic        step;        // Falling edge of generated clock
    logic        last_bit;    // Counters at terminal word and bit
    logic [ADDR_W-1:0] addr_cnt;  // Word address counter
    logic [BIT_W-1:0]  bit_cnt;   // Bit within word

    // Select only counts in configuration mode, never while programming
    assign enabled  = cfg_mode && roe_s && !cs_n_s && !por_busy;
    assign last_bit = (addr_cnt == top_addr) &&
                      (bit_cnt == BIT_W'(WORD_W - 1));

    // Next state decode
    always_comb begin
        next_state = state;
        unique case (state)
            st_idle: begin
                if (!cfg_mode) begin
                    next_state = st_prog;
                end else if (enabled) begin
                    next_state = st_read;
                end
            end
            st_read: begin
                if (!cfg_mode) begin
                    next_state = st_prog;
                end else if (!roe_s) begin
                    next_state = st_idle;
                end else if (step && last_bit) begin
                    next_state = st_done;
                end
            end
            st_done: begin
                if (!cfg_mode) begin
                    next_state = st_prog;
                end else if (!roe_s) begin
                    next_state = st_idle;
                end
            end
            st_prog: begin
                if (cfg_mode) begin
                    next_state = st_idle;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= st_idle;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------------
    // Configuration clock generator
    // ------------------------------------------------------------------------
    logic [7:0] div_cnt;  // Half-period counter
    logic       clk_gen;  // Generated clock level
    logic       running;  // Clock runs while streaming

    assign running = enabled && (state == st_read);
    assign step    = running && clk_gen && (div_cnt == 8'(HALF_CYC - 1));

    // Held low when idle so each stream opens with a rising edge
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt <= 8'h00;
            clk_gen <= 1'b0;
        end else if (!running) begin
            div_cnt <= 8'h00;
            clk_gen <= 1'b0;
        end else if (div_cnt == 8'(HALF_CYC - 1)) begin
            div_cnt <= 8'h00;
            clk_gen <= !clk_gen;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // Output while configuring, input while programming
    assign config_clock_out = clk_gen;
    // Held off for the cycle that leaves programming, pin still an input then
    assign config_clock_oe  = cfg_mode && (state != st_prog) && !por_busy;

    // ------------------------------------------------------------------------
    // Address and bit counters
    // ------------------------------------------------------------------------
    // Cleared at power-up; reloaded while reset/OE is low
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            addr_cnt <= '0;
            bit_cnt  <= '0;
        end else if (!cfg_mode) begin
            addr_cnt <= '0;
            bit_cnt  <= '0;
        end else if (!roe_s || state == st_idle) begin
            addr_cnt <= base_addr;
            bit_cnt  <= '0;
        end else if (step && !last_bit) begin
            if (bit_cnt == BIT_W'(WORD_W - 1)) begin
                bit_cnt  <= '0;
                addr_cnt <= addr_cnt + 1'b1;
            end else begin
                bit_cnt <= bit_cnt + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Storage array and serial data
    // ------------------------------------------------------------------------
    logic [WORD_W-1:0] mem [2**ADDR_W];  // Stored bitstream
    logic [ADDR_W-1:0] mem_addr;         // Software access pointer
    logic              mem_we;           // Software word write
    logic              bit_q;            // Bit on the data pin

    // Array has no reset; it holds the image
    always_ff @(posedge clk_sys) begin
        if (mem_we) begin
            mem[mem_addr] <= pwdata[WORD_W-1:0];
        end
    end

    // Presents the current bit, refreshed every cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bit_q <= 1'b0;
        end else begin
            bit_q <= mem[addr_cnt][bit_cnt];
        end
    end

    // Standby and programming leave the line floating; open drain unused
    assign data_out = bit_q;
    assign data_oe  = running && (state == st_read);

    // Low after the last bit; then follows select until reset/OE drops
    assign cascade_out_n = (state == st_done) ? cs_n_s : 1'b1;

    // ------------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------------
    logic acc;      // Access phase of any transfer
    logic hit_st;   // Status decode
    logic hit_ma;   // Pointer decode
    logic hit_md;   // Data decode
    logic md_ok;    // Array writable now

    assign acc    = psel && penable;
    assign hit_st = (paddr == `PROM_OFF_STATUS);
    assign hit_ma = (paddr == `PROM_OFF_MEM_ADDR);
    assign hit_md = (paddr == `PROM_OFF_MEM_DATA);
    // Array only written in programming mode with device selected
    assign md_ok  = !cfg_mode && psel_s;
    assign mem_we = acc && pwrite && hit_md && md_ok;
    assign pready = 1'b1;  // Zero wait states

    // Error on unmapped, status writes, or refused array writes
    assign pslverr = acc && (!(hit_st || hit_ma || hit_md) ||
                     (pwrite && hit_st) || (pwrite && hit_md && !md_ok));

    // Pointer: written directly, steps after each array write
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mem_addr <= ADDR_W'(`PROM_MEM_ADDR_RST);
        end else if (acc && pwrite && hit_ma) begin
            mem_addr <= pwdata[ADDR_W-1:0];
        end else if (mem_we) begin
            mem_addr <= mem_addr + 1'b1;
        end
    end

    // Read mux
    always_comb begin
        prdata = 32'h0000_0000;
        if (hit_st) begin
            prdata[`PROM_ST_STATE_LSB +: 4]     = state;
            prdata[`PROM_ST_CASC_BIT]           = cascade_out_n;
            prdata[`PROM_ST_READY_BIT]          = !por_busy;
            prdata[`PROM_ST_PSEL_BIT]           = psel_s;
            prdata[`PROM_ST_CLKIN_BIT]          = clk_in_s;
            prdata[`PROM_ST_ADDR_LSB +: ADDR_W] = addr_cnt;
            prdata[`PROM_ST_BIT_LSB +: BIT_W]   = bit_cnt;
        end else if (hit_ma) begin
            prdata[ADDR_W-1:0] = mem_addr;
        end else if (hit_md) begin
            prdata[WORD_W-1:0] = mem[mem_addr];
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    property p_roe_low_float;
        @(posedge clk_sys) disable iff (!reset_n)
        (cfg_mode && !roe_s) |-> !data_oe;
    endproperty
    a_roe_low_float: assert property (p_roe_low_float)
        else $error("data driven while reset/OE low");

    property p_roe_low_clear;
        @(posedge clk_sys) disable iff (!reset_n)
        (cfg_mode && !roe_s)[*2] |-> (bit_cnt == '0) && (addr_cnt == $past(base_addr));
    endproperty
    a_roe_low_clear: assert property (p_roe_low_clear)
        else $error("counters not reset by reset/OE low");

    property p_select_freeze;
        @(posedge clk_sys) disable iff (!reset_n)
        (state == st_read && cfg_mode && roe_s && cs_n_s)[*2] |->
            $stable(addr_cnt) && $stable(bit_cnt) && !data_oe;
    endproperty
    a_select_freeze: assert property (p_select_freeze)
        else $error("counter moved or data driven in standby");

    property p_enabled_drive;
        @(posedge clk_sys) disable iff (!reset_n)
        (state == st_read && enabled) |-> data_oe;
    endproperty
    a_enabled_drive: assert property (p_enabled_drive)
        else $error("selected memory not driving data");

    property p_done_release;
        @(posedge clk_sys) disable iff (!reset_n)
        (state == st_read && step && last_bit) |=> !data_oe && !cascade_out_n;
    endproperty
    a_done_release: assert property (p_done_release)
        else $error("terminal count did not release data and cascade");

    property p_cascade_follow;
        @(posedge clk_sys) disable iff (!reset_n)
        (state == st_done) |-> (cascade_out_n == cs_n_s) && !data_oe;
    endproperty
    a_cascade_follow: assert property (p_cascade_follow)
        else $error("cascade not following select");

    property p_ready_por;
        @(posedge clk_sys) disable iff (!reset_n)
        $fell(por_busy) |-> !ready_oe ##1 !ready_oe;
    endproperty
    a_ready_por: assert property (p_ready_por)
        else $error("ready not released after power-up");

    property p_prog_quiet;
        @(posedge clk_sys) disable iff (!reset_n)
        (state == st_prog) |-> !data_oe && !config_clock_oe && cascade_out_n;
    endproperty
    a_prog_quiet: assert property (p_prog_quiet)
        else $error("pins driven in programming mode");

    property p_prog_select;
        @(posedge clk_sys) disable iff (!reset_n)
        mem_we |-> !cfg_mode && psel_s;
    endproperty
    a_prog_select: assert property (p_prog_select)
        else $error("array written while not selected");

    property p_rate;
        @(posedge clk_sys) disable iff (!reset_n)
        $rose(clk_gen) |=> !$fell(clk_gen);
    endproperty
    a_rate: assert property (p_rate)
        else $error("configuration clock too fast");

    c_stream: cover property (@(posedge clk_sys) disable iff (!reset_n)
        state == st_read ##1 state == st_done);
    c_standby: cover property (@(posedge clk_sys) disable iff (!reset_n)
        state == st_read && cs_n_s && roe_s);
    c_prog_write: cover property (@(posedge clk_sys) disable iff (!reset_n)
        mem_we);

    // Divider must never beat the top clock rate
    property p_half_ok;
        @(posedge clk_sys) disable iff (!reset_n)
        running |-> (HALF_CYC >= MIN_HALF);
    endproperty
    a_half_ok: assert property (p_half_ok)
        else $error("half period below rate limit");

endmodule // serial_config_prom_readout

// >>> testbench/fpga_cfg_model.sv
// Model of the configuring device: drives select and reset/OE, takes the bits
`timescale 1ns/1ns
module fpga_cfg_model (
    input  wire logic        clk_sys,       // System clock
    input  wire logic        roe_cmd,       // Wanted reset/OE level
    input  wire logic        cs_n_cmd,      // Wanted select level
    input  wire logic        config_clock,  // Clock from the memory
    input  wire logic        data_line,     // Data wire level
    input  wire logic        data_oe,       // Memory drives the wire
    output logic             reset_or_oe,   // Reset/OE pin
    output logic             chip_select_n, // Select pin
    output logic [15:0]      word,          // Last 16 bits, LSB first
    output logic [15:0]      first_word,    // First 16 bits
    output logic [31:0]      n_bits         // Bits taken
);
    logic clk_q = 1'b0; // Clock level one cycle back
    initial begin
        reset_or_oe   = 1'b0;
        chip_select_n = 1'b1;
        n_bits        = '0;
    end
    // ------------------------------------------------------------
    // Pins change just after an edge, never on the far edge
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        reset_or_oe   <= roe_cmd;
        chip_select_n <= cs_n_cmd;
        clk_q         <= config_clock;
    end
    // Take a bit at each rising clock, mid-bit, so it has settled
    always @(posedge clk_sys) begin
        if (!reset_or_oe) begin
            n_bits <= '0; // Counters restart with the memory
        end else if (config_clock && !clk_q && data_oe) begin
            word   <= {data_line, word[15:1]};
            n_bits <= n_bits + 1;
            if (n_bits == 15) begin
                first_word <= {data_line, word[15:1]};
            end
        end
    end
endmodule // fpga_cfg_model

// >>> testbench/tb_top.sv
// Self-checking bench of the configuration memory readout block
`timescale 1ns/1ns
`include "prom_params.svh"
module tb_top;
    logic        clk_sys = 1'b0, reset_n = 1'b0, roe_cmd = 1'b0, cs_n_cmd = 1'b1;
    logic        isp_mode_select_n = 1'b1, paging_enable = 1'b0, pds = 1'b0;
    logic [1:0]  page_select = 2'b00;
    logic        config_clock_in = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd, n_bits;
    logic        reset_or_oe, chip_select_n, cco, cc_oe, data_out, data_oe, er;
    logic        cascade_out_n, ready_oe, pready, pslverr, ro;
    logic [15:0] word, first_word;
    wire         data_line = data_oe ? data_out : 1'b1; // Pull-up when released
    int          n_mismatch = 0, checks_done = 0, base, nw;
    localparam logic [2:0] ROWS [5] = '{3'b100, 3'b101, 3'b110, 3'b111, 3'b000};
    serial_config_prom_readout #(.ADDR_W(6)) DUT (.clk_sys(clk_sys), .reset_n(reset_n),
        .reset_or_oe(reset_or_oe), .chip_select_n(chip_select_n),
        .isp_mode_select_n(isp_mode_select_n), .paging_enable(paging_enable),
        .page_select(page_select), .program_device_select(pds),
        .config_clock_in(config_clock_in), .config_clock_out(cco), .config_clock_oe(cc_oe),
        .data_in(data_line), .data_out(data_out), .data_oe(data_oe),
        .cascade_out_n(cascade_out_n), .ready_out(ro), .ready_oe(ready_oe), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    fpga_cfg_model far (.clk_sys(clk_sys), .roe_cmd(roe_cmd), .cs_n_cmd(cs_n_cmd),
        .config_clock(cco), .data_line(data_line), .data_oe(data_oe),
        .reset_or_oe(reset_or_oe), .chip_select_n(chip_select_n), .word(word),
        .first_word(first_word), .n_bits(n_bits));
    // ------------------------------------------------------------
    // Clocks, watchdog and shared tasks
    // ------------------------------------------------------------
    initial forever #10 clk_sys = ~clk_sys;
    // Programming clock pin, free phase, 160 ns
    initial begin #7; forever #80 config_clock_in = ~config_clock_in; end
    initial begin #1000000; n_mismatch++; test_done(); end // Whole run is ~0.35 ms
    function automatic logic [15:0] pat(input int i);
        return 16'h5a00 ^ (16'h0103 * i[15:0]);
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin n_mismatch++; $display("ERROR %0t %h %h", $time, got, exp); end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask
    // One APB transfer; answer taken at the rising edge that sees pready high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic test_done;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        cyc(12); reset_n = 1'b1; cyc(1);
        chk_bit(ready_oe, 1'b1);
        chk_bit(ro, 1'b0);
        chk_bit(data_oe, 1'b0);
        chk_bit(cascade_out_n, 1'b1);
        cyc(60); chk_bit(ready_oe, 1'b0);
        apb(1'b0, `PROM_OFF_STATUS, 32'h0); // Clock pin bit masked, free running
        chk_word(rd & 32'hffff_ff7f, 32'h1 | (32'h1 << `PROM_ST_CASC_BIT) |
            (32'h1 << `PROM_ST_READY_BIT));
        isp_mode_select_n = 1'b0; pds = 1'b1; cyc(5);
        chk_bit(cc_oe, 1'b0);
        apb(1'b1, `PROM_OFF_MEM_ADDR, 32'h0);
        for (int i = 0; i < 64; i++) apb(1'b1, `PROM_OFF_MEM_DATA, {16'h0, pat(i)});
        apb(1'b1, `PROM_OFF_STATUS, 32'h1); chk_bit(er, 1'b1); // Read-only place
        apb(1'b0, 12'h00c, 32'h0); chk_bit(er, 1'b1); // Unmapped
        pds = 1'b0;
        apb(1'b1, `PROM_OFF_MEM_DATA, 32'hffff); chk_bit(er, 1'b1);
        apb(1'b1, `PROM_OFF_MEM_ADDR, 32'h5);
        apb(1'b0, `PROM_OFF_MEM_DATA, 32'h0); chk_word({16'h0, rd[15:0]}, {16'h0, pat(5)});
        isp_mode_select_n = 1'b1; cyc(5); chk_bit(cc_oe, 1'b1);
        // Each row: page mode, page; stream one page or the whole array
        for (int r = 0; r < 5; r++) begin
            roe_cmd = 1'b0; cs_n_cmd = 1'b0; {paging_enable, page_select} = ROWS[r];
            base = ROWS[r][2] ? 16 * ROWS[r][1:0] : 0;
            nw = ROWS[r][2] ? 16 : 64;
            cyc(8); roe_cmd = 1'b1;
            for (int k = 0; k < 12000 && cascade_out_n !== 1'b0; k++) cyc(1);
            chk_word(n_bits, 16 * nw);
            chk_word({16'h0, first_word}, {16'h0, pat(base)});
            chk_word({16'h0, word}, {16'h0, pat(base + nw - 1)});
            chk_bit(data_oe, 1'b0);
            cs_n_cmd = 1'b1; cyc(6); chk_bit(cascade_out_n, 1'b1);
            cs_n_cmd = 1'b0; cyc(6); chk_bit(cascade_out_n, 1'b0);
            roe_cmd = 1'b0; cyc(6); chk_bit(cascade_out_n, 1'b1);
        end
        cs_n_cmd = 1'b1; cyc(6); roe_cmd = 1'b1; cyc(40);
        chk_bit(data_oe, 1'b0);
        cs_n_cmd = 1'b0; cyc(10); chk_bit(data_oe, 1'b1);
        cyc(300); cs_n_cmd = 1'b1; cyc(6); nw = n_bits; cyc(40);
        chk_word(n_bits, nw);
        chk_bit(data_oe, 1'b0);
        roe_cmd = 1'b0; cyc(6); chk_bit(data_oe, 1'b0);
        cs_n_cmd = 1'b0; roe_cmd = 1'b1;
        for (int k = 0; k < 500 && n_bits < 16; k++) cyc(1);
        chk_word({16'h0, word}, {16'h0, pat(0)});
        test_done();
    end
endmodule // tb_top
